// file: core/vsr_sync_ref.v
// Purpose: Drives or takes the two sync reference pins and picks hsync source.
// Assumes: All inputs synchronous to clk; start/end values within line length.
// Notes:   Pins are split into in/out/enable; enable is low while driving.
`timescale 1ns/1ps
`include "vsr_defs.vh"

module vsr_sync_ref (
    input  wire        clk,                        // Pixel clock
    input  wire        rst_b,                      // Synchronous reset, active low
    input  wire        ctrl_wr,                    // Control byte write strobe
    input  wire [7:0]  ctrl_addr,                  // Subaddress of the write
    input  wire [7:0]  ctrl_wdata,                 // Control byte write data
    output wire [7:0]  ctrl_rdata,                 // Control byte read back
    input  wire        embedded_sync_mode,         // High: sync from embedded codes
    input  wire        line_length_select,         // 0: 864, 1: 858 clocks
    input  wire        alternating_v_standard_sel, // 1: alternating V standard
    input  wire [10:0] pin_b_pulse_start,          // Pin B pulse start pixel
    input  wire [10:0] pin_b_pulse_end,            // Pin B pulse end pixel
    input  wire [9:0]  first_active_line,          // First unblanked line
    input  wire [9:0]  last_active_line,           // Last unblanked line
    input  wire        emb_hsync,                  // Decoded embedded line start pulse
    input  wire        sync_ref_pin_a_in,          // Pin A level in
    output reg         sync_ref_pin_a_out,         // Pin A level out
    output wire        sync_ref_pin_a_oe_b,        // Pin A driver enable, low drives
    input  wire        sync_ref_pin_b_in,          // Pin B level in
    output reg         sync_ref_pin_b_out,         // Pin B level out
    output wire        sync_ref_pin_b_oe_b,        // Pin B driver enable, low drives
    output reg         hsync_event,                // Internal line start pulse
    output reg         vsync_event,                // Internal field sync pulse
    output reg         active_video,               // Internal blanking-not level
    output reg         odd_field,                  // Current field is the odd one
    output wire        alt_v_encoding              // Alternating V encoding active
);

    // Stored state
    reg  [7:0]  ctrl;            // Control byte
    reg  [10:0] pix;             // Pixel counter within line
    reg  [9:0]  line;            // Line counter within frame
    reg  [2:0]  seq;             // Field sequence counter
    reg         a_prev;          // Pin A level, previous cycle
    reg         b_prev;          // Pin B level, previous cycle
    reg         a_reg;           // Pin A level, registered
    reg         b_reg;           // Pin B level, registered

    // Control byte fields, one name per job
    wire        b_pol    = ctrl[`VSR_B_POL_BIT];
    wire        b_out_en = ctrl[`VSR_B_DIR_BIT];
    wire        blank_form = ctrl[`VSR_BLANK_FORM_BIT];
    wire        a_pol    = ctrl[`VSR_A_POL_BIT];
    wire        a_out_en = ctrl[`VSR_A_DIR_BIT];
    wire        hsrc     = ctrl[`VSR_HSRC_BIT];
    wire [1:0]  a_type   = ctrl[`VSR_A_TYPE_HI:`VSR_A_TYPE_LO];

    // Derived timing and edge terms
    wire [10:0] last_pix;        // Last pixel index of the line
    wire [9:0]  last_line;       // Last line index of the frame
    wire [9:0]  field2_line;     // First line of the even field
    wire [2:0]  seq_last;        // Last field of the sequence
    wire        a_lvl;           // Pin A after polarity
    wire        b_lvl;           // Pin B after polarity
    wire        a_edge;          // Active edge on pin A
    wire        b_edge;          // Active edge on pin B
    wire        line_end;        // Last pixel of line
    wire        h_window;        // Pixel in start..end window
    wire        v_window;        // Line in first..last active range
    wire        field_line;      // Vertical sync lines of this field
    wire        h_trig;          // Selected horizontal trigger
    wire        v_trig;          // Vertical trigger from pin A
    wire        b_blank_in;      // Pin B taken as blanking input
    reg         next_odd;        // Field flag for next cycle
    reg  [9:0]  fline;           // Line within field
    reg         vsync_now;       // Vertical sync lines active
    reg         a_drive;         // Pin A active level before polarity

    // Line length follows the select bit
    assign last_pix    = line_length_select ? `VSR_LAST_PIX_858 : `VSR_LAST_PIX_864;
    // Frame and field lengths follow the same select bit
    assign last_line   = line_length_select ? `VSR_LAST_LINE_525 : `VSR_LAST_LINE_625;
    assign field2_line = line_length_select ? `VSR_FIELD2_525 : `VSR_FIELD2_625;
    // Standard bit also sets sequence length
    assign seq_last    = alternating_v_standard_sel ? `VSR_SEQ_LAST_ALT : `VSR_SEQ_LAST_NALT;
    assign alt_v_encoding = alternating_v_standard_sel;

    // Register read always shows the stored byte
    assign ctrl_rdata = ctrl;

    // Control byte; only its own subaddress is taken
    // Writes to other subaddresses pass without any effect
    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= `VSR_CTRL_RESET;
        end else if (ctrl_wr && (ctrl_addr == `VSR_CTRL_ADDR)) begin
            ctrl <= ctrl_wdata;
        end
    end

    // Drivers off while a pin is an input
    assign sync_ref_pin_a_oe_b = ~a_out_en;
    assign sync_ref_pin_b_oe_b = ~b_out_en;

    // Input edges are judged after polarity
    // Limitation: a polarity write flips the level and may fake one edge
    assign a_lvl  = a_reg ^ a_pol;
    assign b_lvl  = b_reg ^ b_pol;
    assign a_edge = ~a_out_en & a_lvl & ~a_prev;
    assign b_edge = ~b_out_en & b_lvl & ~b_prev;

    // Pin levels sampled, previous kept for edge test
    // Sampled while driving too, so edge history stays current
    always @(posedge clk) begin
        if (!rst_b) begin
            a_reg  <= 1'b0;
            b_reg  <= 1'b0;
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end else begin
            a_reg  <= sync_ref_pin_a_in;
            b_reg  <= sync_ref_pin_b_in;
            a_prev <= a_lvl;
            b_prev <= b_lvl;
        end
    end

    // Horizontal source choice
    // Embedded codes win while the sync mode is high and source select is 0; with select 1 nothing triggers
    assign h_trig = embedded_sync_mode ? (~hsrc & emb_hsync)
                  : (hsrc ? b_edge : a_edge);
    // Vertical trigger is any active pin A edge; meaning set by type
    assign v_trig = a_edge;
    assign line_end = (pix == last_pix);

    // Pixel and line counters, realigned by triggers
    // Trigger wins over wrap, so an early edge shortens the line
    // Start past the line length never matches; an end past it runs the window to line end
    always @(posedge clk) begin
        if (!rst_b) begin
            pix  <= 11'h000;
            line <= 10'h000;
        end else begin
            if (h_trig || line_end) begin
                pix <= 11'h000;
            end else begin
                pix <= pix + 11'h001;
            end
            if (v_trig) begin
                // Each input type marks the start of a field
                line <= (a_type == `VSR_TYPE_FRAME_SYNC && !a_lvl) ? field2_line : 10'h000;
            end else if (h_trig || line_end) begin
                line <= (line == last_line) ? 10'h000 : line + 10'h001;
            end
        end
    end

    // Field flag and line within field
    // Even field counts its lines from its own first line
    always @* begin
        next_odd  = (line < field2_line);
        fline     = next_odd ? line : line - field2_line;
        vsync_now = (fline < `VSR_VSYNC_LINES);
    end
    assign field_line = vsync_now;

    // Field sequence counter steps at each field start
    // A field sequence input edge restarts the count at zero
    always @(posedge clk) begin
        if (!rst_b) begin
            seq         <= 3'h0;
            odd_field   <= 1'b1;
            vsync_event <= 1'b0;
        end else begin
            odd_field   <= next_odd;
            vsync_event <= (next_odd != odd_field) || v_trig;
            if (v_trig && a_type == `VSR_TYPE_FIELD_SEQ) begin
                seq <= 3'h0;
            end else if (next_odd != odd_field) begin
                seq <= (seq >= seq_last) ? 3'h0 : seq + 3'h1;
            end
        end
    end

    // Pin A pulse by signal type
    // Output type and input type share one field
    always @* begin
        case (a_type)
            `VSR_TYPE_FIELD_VSYNC: a_drive = field_line;
            `VSR_TYPE_FRAME_SYNC:  a_drive = odd_field;
            `VSR_TYPE_FIELD_SEQ:   a_drive = field_line && (seq == 3'h0);
            default:               a_drive = 1'b0;  // Code 11 must not be used
        endcase
    end

    // Windows bounded by programmed start/end and lines
    assign h_window = (pix >= pin_b_pulse_start) && (pix <= pin_b_pulse_end);
    assign v_window = (fline >= first_active_line) && (fline <= last_active_line);
    // Pin B blanking input only while it listens and codes are off
    assign b_blank_in = ~b_out_en & ~embedded_sync_mode & blank_form;

    // Pin outputs and internal blanking, all registered
    // One cycle of latency on each output set here keeps pins glitch free
    always @(posedge clk) begin
        if (!rst_b) begin
            sync_ref_pin_a_out <= 1'b0;
            sync_ref_pin_b_out <= 1'b0;
            hsync_event        <= 1'b0;
            active_video       <= 1'b0;
        end else begin
            sync_ref_pin_a_out <= a_drive ^ a_pol;
            // Form 0 keeps the h reference in vertical blanking, form 1 drops it
            if (blank_form) begin
                sync_ref_pin_b_out <= (h_window & v_window) ^ b_pol;
            end else begin
                sync_ref_pin_b_out <= h_window ^ b_pol;
            end
            hsync_event <= h_trig;
            // Blanking from pin B only in input form 1, else own timing
            if (b_blank_in) begin
                active_video <= b_lvl;
            end else begin
                active_video <= h_window & v_window;
            end
        end
    end

endmodule // vsr_sync_ref

// file: core/vsr_defs.vh
// Purpose: Constants for the sync reference pin port.
// Assumes: Included by its bare name from core/vsr_sync_ref.v.
// Notes:   Control byte layout and counter figures live here only.
// Operation
// - Pin B polarity bit inverts output and edge
// - Pin B direction: 0 input, 1 output
// - Blanking form 0: h reference, also in vertical blanking
// - Blanking form 1: blanking pulse, vertical suppressed
// - Pin B input, form 0: hsync only
// - Pin B input, form 1: hsync plus blanking
// - Pin A polarity bit inverts output and edge
// - Pin A direction: 0 input, 1 output
// - Hsync from pin A or embedded codes
// - Source select 1: hsync from pin B
// - Pin A type 00 vsync, 01 frame sync
// - Type 10: field sequence, every 4 or 8
// - Start and end values bound pin B pulse
// - Line length 864 or 858 pixel clocks
// - Standard select: alternating V when 1
`ifndef VSR_DEFS_VH
`define VSR_DEFS_VH

// Control byte subaddress and reset value
`define VSR_CTRL_ADDR      8'h6B
`define VSR_CTRL_RESET     8'h00

// Control byte field positions
`define VSR_B_POL_BIT      7
`define VSR_B_DIR_BIT      6
`define VSR_BLANK_FORM_BIT 5
`define VSR_A_POL_BIT      4
`define VSR_A_DIR_BIT      3
`define VSR_HSRC_BIT       2
`define VSR_A_TYPE_HI      1
`define VSR_A_TYPE_LO      0

// Pin A signal type codes
`define VSR_TYPE_FIELD_VSYNC 2'h0
`define VSR_TYPE_FRAME_SYNC  2'h1
`define VSR_TYPE_FIELD_SEQ   2'h2

// Pixel clocks per line, last index of each
`define VSR_LAST_PIX_864   11'h35F
`define VSR_LAST_PIX_858   11'h359

// Lines per frame (last index) and first line of second field
`define VSR_LAST_LINE_625  10'h270
`define VSR_LAST_LINE_525  10'h20C
`define VSR_FIELD2_625     10'h139
`define VSR_FIELD2_525     10'h107

// Lines of vertical sync at the head of each field
`define VSR_VSYNC_LINES    10'h003

// Fields in a sequence, last index for each standard
`define VSR_SEQ_LAST_ALT   3'h7
`define VSR_SEQ_LAST_NALT  3'h3

`endif

// file: sim/vsr_checker.sv
// Purpose: Assertions on the sync reference port.
// Assumes: Sees only the top ports; one clock domain.
// Notes:   Edge to hsync allowed 1 to 3 clocks.
`timescale 1ns/1ps
module vsr_checker (
    input logic       clk,
    input logic       rst_b,
    input logic       ctrl_wr,
    input logic [7:0] ctrl_addr,
    input logic [7:0] ctrl_wdata,
    input logic [7:0] ctrl_rdata,
    input logic       embedded_sync_mode,
    input logic       emb_hsync,
    input logic       sync_ref_pin_a_in,
    input logic       sync_ref_pin_b_in,
    input logic       sync_ref_pin_a_oe_b,
    input logic       sync_ref_pin_b_oe_b,
    input logic       hsync_event
);
    wire [7:0] c = ctrl_rdata; // Stored control byte
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_reset_clears: assert property (disable iff (1'b0)
        !rst_b |=> c == 8'h00 && sync_ref_pin_a_oe_b && sync_ref_pin_b_oe_b) else $error("reset");
    chk_write_taken: assert property (
        ctrl_wr && ctrl_addr == 8'h6B |=> c == $past(ctrl_wdata)) else $error("write lost");
    chk_other_ignored: assert property (
        ctrl_wr && ctrl_addr != 8'h6B |=> $stable(c)) else $error("foreign write taken");
    chk_pin_a_drive: assert property (sync_ref_pin_a_oe_b == !c[3]) else $error("pin A dir");
    chk_pin_b_drive: assert property (sync_ref_pin_b_oe_b == !c[6]) else $error("pin B dir");
    chk_pin_a_hsync: assert property (
        !c[3] && !c[2] && !embedded_sync_mode && (c[4] ? $fell(sync_ref_pin_a_in) :
        $rose(sync_ref_pin_a_in)) |-> ##[1:3] hsync_event) else $error("no hsync from A");
    chk_pin_b_hsync: assert property (
        !c[6] && c[2] && !embedded_sync_mode && (c[7] ? $fell(sync_ref_pin_b_in) :
        $rose(sync_ref_pin_b_in)) |-> ##[1:3] hsync_event) else $error("no hsync from B");
    chk_code_hsync: assert property (
        !c[2] && embedded_sync_mode && emb_hsync |-> ##[1:3] hsync_event) else $error("no code hsync");
endmodule // vsr_checker
bind vsr_sync_ref vsr_checker u_chk (.clk, .rst_b, .ctrl_wr, .ctrl_addr, .ctrl_wdata,
    .ctrl_rdata, .embedded_sync_mode, .emb_hsync, .sync_ref_pin_a_in, .sync_ref_pin_b_in,
    .sync_ref_pin_a_oe_b, .sync_ref_pin_b_oe_b, .hsync_event);

// file: sim/vsr_src_model.sv
// Purpose: Upstream decoder driving sync pulses into both pins.
// Assumes: Requests arrive just after a clock edge.
// Notes:   Pulses last 3 clocks, active high; idle low.
`timescale 1ns/1ps
module vsr_src_model (
    input  logic clk,
    input  logic fire_a,
    input  logic fire_b,
    input  logic hold_b,
    output logic pin_a,
    output logic pin_b
);
    logic [2:0] sh_a = 3'h0; // Pulse shape on pin A
    logic [2:0] sh_b = 3'h0; // Pulse shape on pin B
    // Three clocks, so the pulse survives the input register
    always @(posedge clk) begin
        sh_a <= fire_a ? 3'h7 : {1'b0, sh_a[2:1]};
        sh_b <= fire_b ? 3'h7 : {1'b0, sh_b[2:1]};
    end
    assign pin_a = sh_a[0]; // Field sync pulse of the chosen type
    assign pin_b = hold_b | sh_b[0]; // Held level doubles as blanking
endmodule // vsr_src_model

// file: sim/vsr_testbench.sv
// Purpose: Self-checking bench for the sync reference port.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes:   Pin B window is pixels 10 to 19.
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_b = 0, ctrl_wr = 0, embedded_sync_mode = 0, emb_hsync = 0;
    logic line_length_select = 0, alternating_v_standard_sel = 1, fire_a = 0, fire_b = 0;
    logic hold_b = 0, seen;
    logic [7:0] ctrl_addr = 8'h00, ctrl_wdata = 8'h00;
    logic [10:0] pin_b_pulse_start = 11'h00A, pin_b_pulse_end = 11'h013;
    logic [9:0] first_active_line = 10'h000, last_active_line = 10'h3FF;
    wire [7:0] ctrl_rdata;
    wire sync_ref_pin_a_out, sync_ref_pin_b_out, sync_ref_pin_a_oe_b, sync_ref_pin_b_oe_b;
    wire hsync_event, vsync_event, active_video, odd_field, alt_v_encoding, src_a, src_b;
    // Wire level: ours while the driver is on, else the source
    wire sync_ref_pin_a_in = sync_ref_pin_a_oe_b ? src_a : sync_ref_pin_a_out;
    wire sync_ref_pin_b_in = sync_ref_pin_b_oe_b ? src_b : sync_ref_pin_b_out;
    int fails = 0, compares = 0, n;
    vsr_sync_ref dut (.clk, .rst_b, .ctrl_wr, .ctrl_addr, .ctrl_wdata, .ctrl_rdata,
        .embedded_sync_mode, .line_length_select, .alternating_v_standard_sel,
        .pin_b_pulse_start, .pin_b_pulse_end, .first_active_line, .last_active_line,
        .emb_hsync, .sync_ref_pin_a_in, .sync_ref_pin_a_out, .sync_ref_pin_a_oe_b,
        .sync_ref_pin_b_in, .sync_ref_pin_b_out, .sync_ref_pin_b_oe_b, .hsync_event,
        .vsync_event, .active_video, .odd_field, .alt_v_encoding);
    vsr_src_model src (.clk, .fire_a, .fire_b, .hold_b, .pin_a(src_a), .pin_b(src_b));
    initial forever #50 clk = ~clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr_ctrl(input logic [7:0] a, input logic [7:0] d);
        ctrl_wr = 1;
        ctrl_addr = a;
        ctrl_wdata = d;
        tick(1);
        ctrl_wr = 0;
        tick(1);
    endtask
    // Clocks of one line at level v on pin B
    task automatic count_lvl(input logic v, output int k);
        k = 0;
        repeat (line_length_select ? 858 : 864) begin
            tick(1);
            k += (sync_ref_pin_b_out === v);
        end
    endtask
    // Clocks up to the next rising edge on pin B, bounded
    task automatic wait_rise(output int k);
        logic p;
        k = 0;
        do begin
            p = sync_ref_pin_b_out;
            tick(1);
            k++;
        end while (!(p === 1'b0 && sync_ref_pin_b_out === 1'b1) && k < 2000);
    endtask
    task automatic t_regs;
        check(ctrl_rdata, 16'h0000);
        check({sync_ref_pin_a_oe_b, sync_ref_pin_b_oe_b, odd_field, alt_v_encoding}, 4'hF);
        for (int t = 0; t < 3; t++) begin
            wr_ctrl(8'h6B, 8'(t));
            check(ctrl_rdata, 16'(t));
        end
        wr_ctrl(8'h6A, 8'hFF);
        check(ctrl_rdata, 16'h0002);
        alternating_v_standard_sel = 0;
        tick(1);
        check(alt_v_encoding, 16'h0000);
        alternating_v_standard_sel = 1;
    endtask
    // Each hsync source in turn, falling edge last
    task automatic t_hsync;
        for (int k = 0; k < 4; k++) begin
            embedded_sync_mode = (k == 2);
            wr_ctrl(8'h6B, k[0] ? {k[1], 7'h04} : 8'h00);
            fire_a = (k == 0);
            fire_b = k[0];
            emb_hsync = (k == 2);
            tick(1);
            fire_a = 0;
            fire_b = 0;
            emb_hsync = 0;
            seen = hsync_event;
            repeat (8) begin
                tick(1);
                seen |= hsync_event;
            end
            check(seen, 16'h0001);
        end
    endtask
    task automatic t_blank;
        wr_ctrl(8'h6B, 8'h24);
        hold_b = 1;
        tick(4);
        check(active_video, 16'h0001);
        hold_b = 0;
        tick(4);
        check(active_video, 16'h0000);
    endtask
    // Field sequence edge restarts the frame, then pin A drives each type
    task automatic t_vs;
        wr_ctrl(8'h6B, 8'h02);
        fire_a = 1;
        tick(1);
        fire_a = 0;
        tick(2);
        check(vsync_event, 16'h0001);
        tick(6);
        wr_ctrl(8'h6B, 8'h0A);
        tick(1800);
        check(sync_ref_pin_a_out, 16'h0001);
        wr_ctrl(8'h6B, 8'h08);
        check(sync_ref_pin_a_out, 16'h0001);
        wr_ctrl(8'h6B, 8'h09);
        check(sync_ref_pin_a_out, 16'h0001);
        wr_ctrl(8'h6B, 8'h08);
        tick(858);
        check(sync_ref_pin_a_out, 16'h0000);
    endtask
    task automatic t_horizontal_reference_pulse;
        wr_ctrl(8'h6B, 8'h40);
        check({sync_ref_pin_a_oe_b, sync_ref_pin_b_oe_b}, 16'h0002);
        count_lvl(1'b1, n);
        check(16'(n), 16'h000A);
        wait_rise(n);
        wait_rise(n);
        check(16'(n), 16'h0360);
        line_length_select = 1;
        wait_rise(n);
        wait_rise(n);
        check(16'(n), 16'h035A);
        wr_ctrl(8'h6B, 8'hC0);
        count_lvl(1'b0, n);
        check(16'(n), 16'h000A);
        first_active_line = 10'h2BC;
        last_active_line = 10'h2BC;
        wr_ctrl(8'h6B, 8'h60);
        count_lvl(1'b1, n);
        check(16'(n), 16'h0000);
    endtask
    task automatic print_verdict;
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(6);
        rst_b = 1;
        t_regs();
        t_hsync();
        t_blank();
        t_vs();
        t_horizontal_reference_pulse();
        print_verdict();
    end
    // Hang guard, well past the expected run
    initial begin
        #3000000;
        fails++;
        print_verdict();
    end
endmodule // testbench
